// ---- rtl/pils_pkg.sv ----
// pils_pkg: encodings, field positions and constants for the custom
// post-increment / register-register load-store unit.
// assumes a 32-bit core with a 32-register file and a simple req/gnt/rvalid data port.
package pils_pkg;

  localparam int XLEN = 32;

  // opcodes
  localparam logic [6:0] OPC_LD_IMM = 7'h0b; // 000 1011
  localparam logic [6:0] OPC_MEM    = 7'h2b; // 010 1011

  // funct3 values
  localparam logic [2:0] F3_B   = 3'h0;
  localparam logic [2:0] F3_H   = 3'h1;
  localparam logic [2:0] F3_W   = 3'h2;
  localparam logic [2:0] F3_REG = 3'h3;
  localparam logic [2:0] F3_BU  = 3'h4;
  localparam logic [2:0] F3_HU  = 3'h5;

  // funct7 layout: bit 4 store, bit 2 no increment, bit 3 unsigned, bits 1:0 size
  localparam int F7_ST  = 4;
  localparam int F7_NOI = 2;
  localparam int F7_UNS = 3;
  localparam logic [6:0] F7_FIXED_MASK = 7'h60; // bits 6:5 must be zero

  // instruction field positions
  localparam int OPC_LO = 0;
  localparam int OPC_HI = 6;
  localparam int RD_LO  = 7;
  localparam int RD_HI  = 11;
  localparam int F3_LO  = 12;
  localparam int F3_HI  = 14;
  localparam int RS1_LO = 15;
  localparam int RS1_HI = 19;
  localparam int RS2_LO = 20;
  localparam int RS2_HI = 24;
  localparam int F7_LO  = 25;
  localparam int F7_HI  = 31;

  // access sizes
  localparam logic [1:0] SZ_B = 2'h0;
  localparam logic [1:0] SZ_H = 2'h1;
  localparam logic [1:0] SZ_W = 2'h2;

  localparam logic [4:0] REG_ZERO = 5'h00;

  typedef enum logic [1:0] {
    PILS_IDLE = 2'b00,
    PILS_REQ  = 2'b01,
    PILS_WAIT = 2'b10,
    PILS_WB   = 2'b11
  } pils_state_t;

endpackage

// ---- rtl/pils_dec.sv ----
// pils_dec: combinational decode of one instruction word.
// assumes the word is stable while valid; result is registered by the caller.
`timescale 1ns/1ns
module pils_dec
  import pils_pkg::*;
#(
  parameter bit CUSTOM_EXT_ENABLE = 1'b1
)
(
  input  wire logic [31:0] instr_i,
  output logic             hit_o,
  output logic             illegal_o,
  output logic             store_o,
  output logic             post_inc_o,
  output logic             reg_off_o,
  output logic             uns_o,
  output logic [1:0]       size_o,
  output logic [4:0]       off_reg_o,
  output logic [31:0]      imm_o
);

  logic [6:0] opc;
  logic [2:0] f3;
  logic [6:0] f7;
  logic       known;

  assign opc = instr_i[OPC_HI:OPC_LO];
  assign f3  = instr_i[F3_HI:F3_LO];
  assign f7  = instr_i[F7_HI:F7_LO];

  ////////////////////////////////////////////////////////////////////////
  // field decode of the three families
  always_comb
  begin
    known      = 1'b0;
    store_o    = 1'b0;
    post_inc_o = 1'b1;
    reg_off_o  = 1'b0;
    uns_o      = 1'b0;
    size_o     = SZ_W;
    off_reg_o  = instr_i[RS2_HI:RS2_LO];
    imm_o      = {{20{instr_i[F7_HI]}}, instr_i[F7_HI:RS2_LO]}; // RQ5 RQ11
    if (opc == OPC_LD_IMM)
    begin
      // RQ4
      known  = (f3 == F3_B) || (f3 == F3_BU) || (f3 == F3_H) || (f3 == F3_HU) || (f3 == F3_W);
      uns_o  = (f3 == F3_BU) || (f3 == F3_HU);
      size_o = (f3 == F3_W) ? SZ_W : ((f3 == F3_H) || (f3 == F3_HU)) ? SZ_H : SZ_B;
    end
    else if (opc == OPC_MEM && f3 == F3_REG)
    begin
      // RQ6 RQ7 RQ9 RQ10
      reg_off_o  = 1'b1;
      store_o    = f7[F7_ST];
      post_inc_o = !f7[F7_NOI];
      uns_o      = f7[F7_UNS];
      size_o     = f7[1:0];
      off_reg_o  = f7[F7_ST] ? instr_i[RD_HI:RD_LO] : instr_i[RS2_HI:RS2_LO];
      known      = ((f7 & F7_FIXED_MASK) == 7'h00) && (f7[1:0] != 2'h3)
                   && !(f7[F7_ST] && f7[F7_UNS]);
    end
    else if (opc == OPC_MEM && (f3 == F3_B || f3 == F3_H || f3 == F3_W))
    begin
      // RQ8 split immediate
      known   = 1'b1;
      store_o = 1'b1;
      size_o  = f3[1:0];
      imm_o   = {{20{instr_i[F7_HI]}}, instr_i[F7_HI:F7_LO], instr_i[RD_HI:RD_LO]};
    end
    hit_o     = known && CUSTOM_EXT_ENABLE; // RQ3
    illegal_o = known && !CUSTOM_EXT_ENABLE; // RQ12
  end

endmodule

// ---- rtl/pils_top.sv ----
// pils_top: executes the custom post-increment and register-register loads/stores.
// assumes the core holds instr_valid_i until instr_done_o or instr_illegal_o,
// supplies rs1/rs2/rs3 operand values, and the data port is req/gnt then rvalid.
//
// How it works
// [RQ1] post-increment uses the old base as address, then base plus offset written back
// [RQ2] load with rd equal to base writes loaded data, incremented address dropped
// [RQ3] custom encodings are accepted only when the extension parameter is one
// [RQ4] immediate post-increment loads: opcode 0001011, imm 31:20, funct3 selects size
// [RQ5] signed loads sign-extend, unsigned zero-extend; immediate offset sign-extended
// [RQ6] register-offset post-increment loads: opcode 0101011, funct3 011, rs2 offset
// [RQ7] register-register loads address base plus rs2, base left unchanged
// [RQ8] immediate post-increment stores: split 12-bit offset in 31:25 and 11:7
// [RQ9] register-offset post-increment stores: offset register from bits 11:7
// [RQ10] register-register stores write at base plus offset register, base unchanged
// [RQ11] immediates are sign-extended and operands treated as signed by default
// [RQ12] with the extension disabled these encodings raise an illegal instruction
`timescale 1ns/1ns
module pils_top
  import pils_pkg::*;
#(
  parameter bit CUSTOM_EXT_ENABLE = 1'b1
)
(
  input  wire logic              sys_clk_i,
  input  wire logic              rstn_i,
  input  wire logic              instr_valid_i,
  input  wire logic [31:0]       instr_i,
  input  wire logic [XLEN-1:0]   rs1_val_i,
  input  wire logic [XLEN-1:0]   rs2_val_i,
  input  wire logic [XLEN-1:0]   rs3_val_i,
  output logic                   instr_done_o,
  output logic                   instr_illegal_o,
  output logic                   rf_we_o,
  output logic [4:0]             rf_waddr_o,
  output logic [XLEN-1:0]        rf_wdata_o,
  output logic                   data_req_o,
  output logic                   data_we_o,
  output logic [3:0]             data_be_o,
  output logic [XLEN-1:0]        data_addr_o,
  output logic [XLEN-1:0]        data_wdata_o,
  input  wire logic              data_gnt_i,
  input  wire logic              data_rvalid_i,
  input  wire logic [XLEN-1:0]   data_rdata_i
);

  ////////////////////////////////////////////////////////////////////////
  // decode
  logic        dec_hit;
  logic        dec_ill;
  logic        dec_st;
  logic        dec_pi;
  logic        dec_ro;
  logic        dec_uns;
  logic [1:0]  dec_sz;
  logic [4:0]  dec_offr;
  logic [31:0] dec_imm;

  pils_dec #(
    .CUSTOM_EXT_ENABLE (CUSTOM_EXT_ENABLE)
  ) u_dec (
    .instr_i    (instr_i),
    .hit_o      (dec_hit),
    .illegal_o  (dec_ill),
    .store_o    (dec_st),
    .post_inc_o (dec_pi),
    .reg_off_o  (dec_ro),
    .uns_o      (dec_uns),
    .size_o     (dec_sz),
    .off_reg_o  (dec_offr),
    .imm_o      (dec_imm)
  );

  ////////////////////////////////////////////////////////////////////////
  // state
  pils_state_t         state_q,  state_d;
  logic                st_q,     st_d;
  logic                pi_q,     pi_d;
  logic                uns_q,    uns_d;
  logic [1:0]          sz_q,     sz_d;
  logic [4:0]          rd_q,     rd_d;
  logic [4:0]          base_q,   base_d;
  logic [XLEN-1:0]     newb_q,   newb_d;
  logic [XLEN-1:0]     ldat_q,   ldat_d;
  logic                done_q,   done_d;
  logic                ill_q,    ill_d;
  logic                we_q,     we_d;
  logic [4:0]          wa_q,     wa_d;
  logic [XLEN-1:0]     wd_q,     wd_d;
  logic                req_q,    req_d;
  logic                dwe_q,    dwe_d;
  logic [3:0]          be_q,     be_d;
  logic [XLEN-1:0]     addr_q,   addr_d;
  logic [XLEN-1:0]     wdat_q,   wdat_d;

  logic [XLEN-1:0] off_val;
  logic [XLEN-1:0] ext_val;
  logic [XLEN-1:0] shifted;
  logic [1:0]      lane;

  // offset from register (rs2 for loads, rs3 for stores) or sign-extended immediate
  assign off_val = dec_ro ? (dec_st ? rs3_val_i : rs2_val_i) : dec_imm; // RQ5 RQ9
  assign lane    = addr_q[1:0];
  assign shifted = data_rdata_i >> {lane, 3'h0};

  // load extension; signed unless the unsigned variant
  always_comb
  begin
    ext_val = shifted;
    if (sz_q == SZ_B)
      ext_val = uns_q ? {24'h000000, shifted[7:0]} : {{24{shifted[7]}}, shifted[7:0]}; // RQ5
    else if (sz_q == SZ_H)
      ext_val = uns_q ? {16'h0000, shifted[15:0]} : {{16{shifted[15]}}, shifted[15:0]}; // RQ5
  end

  ////////////////////////////////////////////////////////////////////////
  // next state; misaligned accesses are issued as-is, the memory side must cope
  always_comb
  begin
    state_d = state_q;
    st_d    = st_q;
    pi_d    = pi_q;
    uns_d   = uns_q;
    sz_d    = sz_q;
    rd_d    = rd_q;
    base_d  = base_q;
    newb_d  = newb_q;
    ldat_d  = ldat_q;
    done_d  = 1'b0;
    ill_d   = 1'b0;
    we_d    = 1'b0;
    wa_d    = wa_q;
    wd_d    = wd_q;
    req_d   = req_q;
    dwe_d   = dwe_q;
    be_d    = be_q;
    addr_d  = addr_q;
    wdat_d  = wdat_q;
    case (state_q)
      PILS_IDLE:
      begin
        if (instr_valid_i && !done_q && !ill_q)
        begin
          if (dec_ill)
            ill_d = 1'b1; // RQ12
          else if (dec_hit)
          begin
            st_d   = dec_st;
            pi_d   = dec_pi;
            uns_d  = dec_uns;
            sz_d   = dec_sz;
            rd_d   = instr_i[RD_HI:RD_LO];
            base_d = instr_i[RS1_HI:RS1_LO];
            newb_d = rs1_val_i + off_val; // RQ1
            addr_d = dec_pi ? rs1_val_i : (rs1_val_i + off_val); // RQ1 RQ7 RQ10
            dwe_d  = dec_st;
            be_d   = (dec_sz == SZ_W) ? 4'hf : (dec_sz == SZ_H) ? 4'h3 : 4'h1;
            wdat_d = rs2_val_i;
            req_d  = 1'b1;
            state_d = PILS_REQ;
          end
        end
      end
      PILS_REQ:
      begin
        // lanes were already shifted when the address was loaded
        if (data_gnt_i)
        begin
          req_d   = 1'b0;
          state_d = PILS_WAIT;
        end
      end
      PILS_WAIT:
      begin
        if (data_rvalid_i)
        begin
          ldat_d  = ext_val;
          state_d = PILS_WB;
          if (pi_q && base_q != REG_ZERO && !(!st_q && rd_q == base_q)) // RQ2
          begin
            we_d = 1'b1;
            wa_d = base_q;
            wd_d = newb_q; // RQ1
          end
        end
      end
      PILS_WB:
      begin
        // load data written last; the base write was already dropped when rd equals base
        state_d = PILS_IDLE;
        done_d  = 1'b1;
        if (!st_q && rd_q != REG_ZERO)
        begin
          we_d = 1'b1;
          wa_d = rd_q;
          wd_d = ldat_q; // RQ2
        end
      end
      default:
        state_d = PILS_IDLE;
    endcase
    if (state_q == PILS_IDLE && state_d == PILS_REQ)
    begin
      be_d   = be_d << addr_d[1:0];
      wdat_d = wdat_d << {addr_d[1:0], 3'h0};
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_q <= PILS_IDLE;
      st_q    <= 1'b0;
      pi_q    <= 1'b0;
      uns_q   <= 1'b0;
      sz_q    <= SZ_W;
      rd_q    <= REG_ZERO;
      base_q  <= REG_ZERO;
      newb_q  <= '0;
      ldat_q  <= '0;
      done_q  <= 1'b0;
      ill_q   <= 1'b0;
      we_q    <= 1'b0;
      wa_q    <= REG_ZERO;
      wd_q    <= '0;
      req_q   <= 1'b0;
      dwe_q   <= 1'b0;
      be_q    <= 4'h0;
      addr_q  <= '0;
      wdat_q  <= '0;
    end
    else
    begin
      state_q <= state_d;
      st_q    <= st_d;
      pi_q    <= pi_d;
      uns_q   <= uns_d;
      sz_q    <= sz_d;
      rd_q    <= rd_d;
      base_q  <= base_d;
      newb_q  <= newb_d;
      ldat_q  <= ldat_d;
      done_q  <= done_d;
      ill_q   <= ill_d;
      we_q    <= we_d;
      wa_q    <= wa_d;
      wd_q    <= wd_d;
      req_q   <= req_d;
      dwe_q   <= dwe_d;
      be_q    <= be_d;
      addr_q  <= addr_d;
      wdat_q  <= wdat_d;
    end
  end

  assign instr_done_o    = done_q;
  assign instr_illegal_o = ill_q;
  assign rf_we_o         = we_q;
  assign rf_waddr_o      = wa_q;
  assign rf_wdata_o      = wd_q;
  assign data_req_o      = req_q;
  assign data_we_o       = dwe_q;
  assign data_be_o       = be_q;
  assign data_addr_o     = addr_q;
  assign data_wdata_o    = wdat_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  base_wb_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RQ1
    (state_q == PILS_IDLE && instr_valid_i && dec_hit && dec_pi && !done_q && !ill_q)
    |=> (data_addr_o == $past(rs1_val_i)) && (newb_q == $past(rs1_val_i) + $past(off_val)))
    else $error("post-increment address not the old base");

  same_reg_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RQ2
    (rf_we_o && !st_q && pi_q && rd_q == base_q) |-> (rf_wdata_o == ldat_q) && instr_done_o)
    else $error("incremented base overwrote loaded data");

  ext_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RQ3
    (!CUSTOM_EXT_ENABLE) |-> !data_req_o && !rf_we_o)
    else $error("custom access with extension off");

  ill_raise_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RQ12
    (state_q == PILS_IDLE && instr_valid_i && dec_ill && !done_q && !ill_q) |=> instr_illegal_o)
    else $error("disabled encoding not flagged illegal");

  rr_addr_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RQ7 RQ10
    (state_q == PILS_IDLE && instr_valid_i && dec_hit && !dec_pi && !done_q && !ill_q)
    |=> data_req_o && (data_addr_o == $past(rs1_val_i) + $past(off_val)))
    else $error("register-register address wrong");

  no_base_wr_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RQ7 RQ10
    (rf_we_o && !pi_q) |-> (!st_q && rf_waddr_o == rd_q))
    else $error("base written by non-increment access");

  sext_byte_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RQ5 RQ11
    (state_q == PILS_WB && !st_q && sz_q == SZ_B && !uns_q) |-> (ldat_q[31:8] == {24{ldat_q[7]}}))
    else $error("signed byte not sign-extended");

  zext_half_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RQ5
    (state_q == PILS_WB && !st_q && sz_q == SZ_H && uns_q) |-> (ldat_q[31:16] == 16'h0000))
    else $error("unsigned half not zero-extended");

  st_split_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RQ8
    (state_q == PILS_IDLE && instr_valid_i && dec_hit && instr_i[OPC_HI:OPC_LO] == OPC_MEM
     && instr_i[F3_HI:F3_LO] != F3_REG && !done_q && !ill_q)
    |=> data_we_o ##0 (newb_q == $past(rs1_val_i) + {{20{$past(instr_i[F7_HI])}}, $past(instr_i[F7_HI:F7_LO]),
                                                     $past(instr_i[RD_HI:RD_LO])}))
    else $error("split store offset wrong");

  off_reg_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RQ9
    (dec_hit && dec_st && dec_ro) |-> (dec_offr == instr_i[RD_HI:RD_LO]))
    else $error("store offset register not taken from the rd field");

endmodule

// ---- verif/pils_mem_model.sv ----
// pils_mem_model: behavioural data memory for the load-store unit.
// assumes a req/gnt handshake and a one-cycle rvalid response after grant.
`timescale 1ns/1ns
module pils_mem_model
  import pils_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        slow_i,
  input  wire logic        data_req_i,
  input  wire logic        data_we_i,
  input  wire logic [3:0]  data_be_i,
  input  wire logic [31:0] data_addr_i,
  input  wire logic [31:0] data_wdata_i,
  output logic             data_gnt_o,
  output logic             data_rvalid_o,
  output logic [31:0]      data_rdata_o
);
  logic [31:0] mem_q [16];
  logic [1:0]  wait_q;

  ////////////////////////////////////////////////////////////////////////
  // known contents: only the low byte differs per word, top bits set for sign tests
  initial
  begin
    for (int i = 0; i < 16; i++)
      mem_q[i] = 32'h7f8a_80f0 + i;
  end

  // slow mode holds grant back three cycles, so the request must stay up
  assign data_gnt_o = data_req_i && (!slow_i || wait_q == 2'h3);

  // read data is scrambled outside a response so stale data never matches
  always @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wait_q        <= 2'h0;
      data_rvalid_o <= 1'b0;
      data_rdata_o  <= 32'h5a5a_5a5a;
    end
    else
    begin
      wait_q        <= (data_req_i && !data_gnt_o) ? wait_q + 2'h1 : 2'h0;
      data_rvalid_o <= data_gnt_o;
      data_rdata_o  <= data_gnt_o ? mem_q[data_addr_i[5:2]] : ~data_rdata_o;
      for (int b = 0; b < 4; b++)
        if (data_gnt_o && data_we_i && data_be_i[b])
          mem_q[data_addr_i[5:2]][8*b +: 8] <= data_wdata_i[8*b +: 8];
    end
  end
endmodule

// ---- verif/tb_pils_top.sv ----
// tb_pils_top: self-checking bench for the custom load-store unit.
// assumes pils_top and the behavioural data memory model; rs1=x2, rd=x3.
`timescale 1ns/1ns
module tb_pils_top;
  import pils_pkg::*;
  typedef struct {logic [31:0] ins, addr, base, rd; logic [3:0] be;} pils_row_t;
  logic        sys_clk_i = 0, rstn_i = 0, valid = 0, valid2 = 0, slow = 0;
  logic [31:0] instr = 0, rs1 = 32'h10, rs2 = 32'ha5c4, rs3 = 32'hffff_fffc;
  logic        done, ill, we, req, dwe, gnt, rvalid, ill2, we2, gdwe;
  logic [4:0]  wa;
  logic [3:0]  be, gbe;
  logic [31:0] wd, addr, wdat, rdata, gaddr, gwdat, gwa[4], gwd[4];
  int          miscompares = 0, checked = 0, nw, k;
  pils_row_t   rows[24];

  always #20 sys_clk_i = ~sys_clk_i;

  pils_top pils_top_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .instr_valid_i(valid),
    .instr_i(instr), .rs1_val_i(rs1), .rs2_val_i(rs2), .rs3_val_i(rs3), .instr_done_o(done),
    .instr_illegal_o(ill), .rf_we_o(we), .rf_waddr_o(wa), .rf_wdata_o(wd), .data_req_o(req),
    .data_we_o(dwe), .data_be_o(be), .data_addr_o(addr), .data_wdata_o(wdat),
    .data_gnt_i(gnt), .data_rvalid_i(rvalid), .data_rdata_i(rdata));
  // extension disabled: never reaches memory, so its data port is tied off
  pils_top #(.CUSTOM_EXT_ENABLE(1'b0)) pils_top_off_inst (.sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i), .instr_valid_i(valid2), .instr_i(instr), .rs1_val_i(rs1),
    .rs2_val_i(rs2), .rs3_val_i(rs3), .instr_done_o(), .instr_illegal_o(ill2),
    .rf_we_o(we2), .rf_waddr_o(), .rf_wdata_o(), .data_req_o(), .data_we_o(),
    .data_be_o(), .data_addr_o(), .data_wdata_o(), .data_gnt_i(1'b0),
    .data_rvalid_i(1'b0), .data_rdata_i(32'h0));
  pils_mem_model pils_mem_model_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .slow_i(slow),
    .data_req_i(req), .data_we_i(dwe), .data_be_i(be), .data_addr_i(addr),
    .data_wdata_i(wdat), .data_gnt_o(gnt), .data_rvalid_o(rvalid), .data_rdata_o(rdata));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] ld(logic [2:0] f3, logic [11:0] im, logic [4:0] rdf);
    return {im, 5'd2, f3, rdf, OPC_LD_IMM};
  endfunction
  function automatic logic [31:0] rr(logic [6:0] f7);
    return {f7, 5'd4, 5'd2, F3_REG, 5'd3, OPC_MEM};
  endfunction
  // offset -2044 split across both immediate fields
  function automatic logic [31:0] st(logic [2:0] f3);
    return {7'h40, 5'd4, 5'd2, f3, 5'h04, OPC_MEM};
  endfunction
  function automatic logic [31:0] msk(logic [3:0] b);
    return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic finish_test();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one instruction: capture the granted access and every file write until done
  task automatic run(input logic [31:0] ins);
    int n;
    nw = 0;
    gaddr = 'x;
    gdwe = 'x;
    foreach (gwa[j]) gwa[j] = 'x;
    @(negedge sys_clk_i);
    instr = ins;
    valid = 1;
    for (n = 0; n < 40; n++)
    begin
      @(negedge sys_clk_i);
      if (we === 1'b1 && nw < 4)
      begin
        gwa[nw] = {27'h0, wa};
        gwd[nw] = wd;
        nw++;
      end
      if (req === 1'b1 && gnt === 1'b1)
      begin
        gaddr = addr;
        gbe = be;
        gdwe = dwe;
        gwdat = wdat;
      end
      if (done === 1'b1) break;
    end
    valid = 0;
    if (n == 40)
    begin
      chk(32'h0, 32'h1);
      finish_test();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    rows = '{
      '{ld(F3_B, 12'hff8, 5'd3), 32'h10, 32'h8, 32'hffff_fff4, 4'h1},
      '{ld(F3_BU, 12'hff8, 5'd3), 32'h10, 32'h8, 32'hf4, 4'h1},
      '{ld(F3_H, 12'hff8, 5'd3), 32'h10, 32'h8, 32'hffff_80f4, 4'h3},
      '{ld(F3_HU, 12'hff8, 5'd3), 32'h10, 32'h8, 32'h80f4, 4'h3},
      '{ld(F3_W, 12'hff8, 5'd3), 32'h10, 32'h8, 32'h7f8a_80f4, 4'hf},
      '{rr(7'h00), 32'h10, 32'ha5d4, 32'hffff_fff4, 4'h1},
      '{rr(7'h08), 32'h10, 32'ha5d4, 32'hf4, 4'h1},
      '{rr(7'h01), 32'h10, 32'ha5d4, 32'hffff_80f4, 4'h3},
      '{rr(7'h09), 32'h10, 32'ha5d4, 32'h80f4, 4'h3},
      '{rr(7'h02), 32'h10, 32'ha5d4, 32'h7f8a_80f4, 4'hf},
      '{rr(7'h04), 32'ha5d4, 32'h0, 32'hffff_fff5, 4'h1},
      '{rr(7'h0c), 32'ha5d4, 32'h0, 32'hf5, 4'h1},
      '{rr(7'h05), 32'ha5d4, 32'h0, 32'hffff_80f5, 4'h3},
      '{rr(7'h0d), 32'ha5d4, 32'h0, 32'h80f5, 4'h3},
      '{rr(7'h06), 32'ha5d4, 32'h0, 32'h7f8a_80f5, 4'hf},
      '{st(F3_B), 32'h10, 32'hffff_f814, 32'h0, 4'h1},
      '{st(F3_H), 32'h10, 32'hffff_f814, 32'h0, 4'h3},
      '{st(F3_W), 32'h10, 32'hffff_f814, 32'h0, 4'hf},
      '{rr(7'h10), 32'h10, 32'hc, 32'h0, 4'h1},
      '{rr(7'h11), 32'h10, 32'hc, 32'h0, 4'h3},
      '{rr(7'h12), 32'h10, 32'hc, 32'h0, 4'hf},
      '{rr(7'h14), 32'hc, 32'h0, 32'h0, 4'h1},
      '{rr(7'h15), 32'hc, 32'h0, 32'h0, 4'h3},
      '{rr(7'h16), 32'hc, 32'h0, 32'h0, 4'hf}};
    repeat (6) @(negedge sys_clk_i);
    chk({req, we, done, ill}, 32'h0);
    rstn_i = 1;
    // table of ordinary cases: access first, base writeback, then rd
    foreach (rows[i])
    begin
      run(rows[i].ins);
      k = (rows[i].base != 0);
      chk(gaddr, rows[i].addr);
      chk(gbe, rows[i].be);
      chk(gdwe, rows[i].rd == 0);
      if (rows[i].rd == 0) chk(gwdat & msk(gbe), rs2 & msk(rows[i].be));
      if (k) chk(gwa[0], 32'h2);
      if (k) chk(gwd[0], rows[i].base);
      if (rows[i].rd != 0) chk(gwa[k], 32'h3);
      if (rows[i].rd != 0) chk(gwd[k], rows[i].rd);
      chk(nw, k + (rows[i].rd != 0));
    end
    // untouched word from here on, stores above changed the lower ones
    rs1 = 32'h20;
    run(ld(F3_W, 12'h004, 5'd2));
    chk(nw, 1);
    chk(gwd[0], 32'h7f8a_80f8);
    // slow grant: request must survive the stall
    slow = 1;
    run(ld(F3_H, 12'hff8, 5'd3));
    slow = 0;
    chk(gaddr, 32'h20);
    chk(gwd[0], 32'h18);
    chk(gwd[1], 32'hffff_80f8);
    // a standard encoding is not ours and gets no answer; valid low one cycle first
    @(negedge sys_clk_i);
    instr = 32'h0020_81b3;
    valid = 1;
    repeat (8) @(negedge sys_clk_i) chk({req, done, ill}, 32'h0);
    valid = 0;
    // extension disabled: custom word raises illegal, writes nothing
    instr = rows[0].ins;
    valid2 = 1;
    k = 0;
    repeat (8) @(negedge sys_clk_i) if (ill2 === 1'b1) k = 1;
    valid2 = 0;
    chk(k, 1);
    chk(we2, 0);
    // reset in mid-access, then a clean instruction
    @(negedge sys_clk_i);
    valid = 1;
    @(negedge sys_clk_i);
    rstn_i = 0;
    valid = 0;
    @(negedge sys_clk_i);
    chk({req, we, done}, 32'h0);
    rstn_i = 1;
    run(rows[4].ins);
    chk(gwd[1], 32'h7f8a_80f8);
    finish_test();
  end
endmodule
